//--- include/gpio_pkg.sv
// constants, field layouts and carrier types for the gpio port block
// assumes an APB master with 32-bit data and byte addresses on 8 bits
// Notes on behaviour
// - every pin of the seven ports has a direction bit, one output, zero input
// - software writes direction bits one by one without touching neighbours
// - falling edge on port-6 cut input clears all port-6 direction bits
// - falling edge on port-4 cut input clears all port-4 direction bits
// - an output pin drives the port latch, and port writes update the latch
// - reading an output pin returns the latch, not the pin level
// - an input pin is undriven and reads back the level on the pin
// - writing an input pin updates only the latch; pin stays undriven
// - a peripheral output drives the pin whatever the direction bit holds
package gpio_pkg;

  localparam int unsigned PORT_NUM = 7;
  localparam int unsigned PORT_W   = 8;
  localparam int unsigned ADDR_W   = 8;

  // port slots 0..6 stand for ports 1, 2, 4, 5, 6, 7, 8
  localparam logic [2:0] PORT4_SLOT = 3'h2;
  localparam logic [2:0] PORT6_SLOT = 3'h4;

  // register layout: bits [6:4] pick the port slot, bits [3:2] the register
  localparam logic [1:0] REG_DATA    = 2'h0;
  localparam logic [1:0] REG_DIR     = 2'h1;
  localparam logic [1:0] REG_DIR_SET = 2'h2;
  localparam logic [1:0] REG_DIR_CLR = 2'h3;
  localparam logic [2:0] CUT_SLOT    = 3'h7;
  localparam logic [7:0] CUT_STATUS_ADDR = 8'h70;

  // cut status bit positions
  localparam int unsigned CUT_BIT_P4 = 0;
  localparam int unsigned CUT_BIT_P6 = 1;

  localparam logic [PORT_W-1:0] LATCH_RST = 8'h00;
  localparam logic [PORT_W-1:0] DIR_RST   = 8'h00;
  localparam logic [1:0]        CUT_RST   = 2'h0;
  localparam logic [31:0]       RDATA_RST = 32'h0000_0000;

  typedef struct packed {
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] lat;
  } port_ctl_s;

  typedef struct packed {
    logic [PORT_W-1:0] oe;
    logic [PORT_W-1:0] dout;
  } periph_drive_s;

endpackage : gpio_pkg

//--- hw/gpio_cut_detect.sv
// synchroniser and falling-edge detector for one active-low cut pin
// assumes the pin is asynchronous to the clock; idles high after reset
`timescale 1ns/10ps
`default_nettype none
module gpio_cut_detect
  import gpio_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic cut_n_i,
  output logic      fall_o
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } cut_state_s;

  cut_state_s st;
  cut_state_s next_st;

  always_comb
  begin
    next_st      = st;
    next_st.meta = cut_n_i;
    next_st.sync = st.meta;
    next_st.prev = st.sync;
  end

  // reset to high so a high pin gives no edge; a pin held low through reset still gives one edge once reset ends
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st <= '{meta: 1'b1, sync: 1'b1, prev: 1'b1};
    else
      st <= next_st;
  end

  assign fall_o = st.prev & ~st.sync;

endmodule : gpio_cut_detect
`default_nettype wire

//--- hw/gpio_pin_cell.sv
// pin driver and readback for one port
// assumes pin levels are asynchronous and peripheral drive is on this clock
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_cell
  import gpio_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire port_ctl_s         ctl_i,
  input  wire periph_drive_s     periph_i,
  input  wire logic [PORT_W-1:0] pin_i,
  output logic      [PORT_W-1:0] pin_o,
  output logic      [PORT_W-1:0] pin_oe_o,
  output logic      [PORT_W-1:0] readback_o
);

  typedef struct packed {
    logic [PORT_W-1:0] meta;
    logic [PORT_W-1:0] level;
    logic [PORT_W-1:0] dout;
    logic [PORT_W-1:0] oe;
  } cell_state_s;

  cell_state_s st;
  cell_state_s next_st;

  always_comb
  begin
    next_st       = st;
    next_st.meta  = pin_i;
    next_st.level = st.meta;
    // peripheral drive takes the pin regardless of direction
    next_st.oe    = ctl_i.dir | periph_i.oe;
    next_st.dout  = (periph_i.oe & periph_i.dout) | (~periph_i.oe & ctl_i.lat);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign pin_o      = st.dout;
  assign pin_oe_o   = st.oe;
  // latch for outputs keeps loaded pins from corrupting readback
  assign readback_o = (ctl_i.dir & ctl_i.lat) | (~ctl_i.dir & st.level);

endmodule : gpio_pin_cell
`default_nettype wire

//--- hw/gpio_ports.sv
// seven programmable i/o ports with direction, latch and two cut inputs
// assumes an APB master on REF_CLK_I and pins asynchronous to it
`timescale 1ns/10ps
`default_nettype none
module gpio_ports
  import gpio_pkg::*;
(
  input  wire logic                             REF_CLK_I,
  input  wire logic                             SYS_RST_I,
  input  wire logic                             PSEL_I,
  input  wire logic                             PENABLE_I,
  input  wire logic                             PWRITE_I,
  input  wire logic [ADDR_W-1:0]                PADDR_I,
  input  wire logic [31:0]                      PWDATA_I,
  input  wire logic [3:0]                       PSTRB_I,
  output logic      [31:0]                      PRDATA_O,
  output logic                                  PREADY_O,
  output logic                                  PSLVERR_O,
  input  wire logic [PORT_NUM-1:0][PORT_W-1:0]  PIN_I,
  output logic      [PORT_NUM-1:0][PORT_W-1:0]  PIN_O,
  output logic      [PORT_NUM-1:0][PORT_W-1:0]  PIN_OE_O,
  input  wire logic [PORT_NUM-1:0][PORT_W-1:0]  PERIPH_OE_I,
  input  wire logic [PORT_NUM-1:0][PORT_W-1:0]  PERIPH_OUT_I,
  input  wire logic                             PORT4_OUTPUT_CUT_N_I,
  input  wire logic                             PORT6_OUTPUT_CUT_N_I
);

  typedef struct packed {
    logic [PORT_NUM-1:0][PORT_W-1:0] lat;
    logic [PORT_NUM-1:0][PORT_W-1:0] dir;
    logic [1:0]                      cut_seen;
    logic [31:0]                     prdata;
    logic                            pready;
    logic                            pslverr;
  } ports_state_s;

  ports_state_s st;
  ports_state_s next_st;

  logic                            port4_fall;
  logic                            port6_fall;
  logic [PORT_NUM-1:0][PORT_W-1:0] readback;

  // decode of the current address
  logic [2:0]        slot;
  logic [1:0]        reg_sel;
  logic              addr_ok;
  logic              is_cut_reg;
  logic              access;
  logic              wr_take;
  logic              lane0;
  logic [PORT_W-1:0] wbyte;

  gpio_cut_detect u_cut_p4
  (
    .clk_i   (REF_CLK_I),
    .rst_i   (SYS_RST_I),
    .cut_n_i (PORT4_OUTPUT_CUT_N_I),
    .fall_o  (port4_fall)
  );

  gpio_cut_detect u_cut_p6
  (
    .clk_i   (REF_CLK_I),
    .rst_i   (SYS_RST_I),
    .cut_n_i (PORT6_OUTPUT_CUT_N_I),
    .fall_o  (port6_fall)
  );

  genvar gp;
  generate
    for (gp = 0; gp < PORT_NUM; gp++)
    begin : g_port
      port_ctl_s     ctl;
      periph_drive_s drv;

      // one driver per carrier keeps each struct a single net source
      assign ctl = '{dir: st.dir[gp], lat: st.lat[gp]};
      assign drv = '{oe: PERIPH_OE_I[gp], dout: PERIPH_OUT_I[gp]};

      gpio_pin_cell u_cell
      (
        .clk_i      (REF_CLK_I),
        .rst_i      (SYS_RST_I),
        .ctl_i      (ctl),
        .periph_i   (drv),
        .pin_i      (PIN_I[gp]),
        .pin_o      (PIN_O[gp]),
        .pin_oe_o   (PIN_OE_O[gp]),
        .readback_o (readback[gp])
      );
    end
  endgenerate

  always_comb
  begin
    slot       = PADDR_I[6:4];
    reg_sel    = PADDR_I[3:2];
    is_cut_reg = (PADDR_I == CUT_STATUS_ADDR);
    // misaligned, high half and unused slot-7 words answer with an error
    addr_ok    = (PADDR_I[1:0] == 2'h0) && !PADDR_I[7]
                 && ((slot != CUT_SLOT) || is_cut_reg);
    access     = PSEL_I & PENABLE_I;
    // a write lands only on the edge where the answer is given
    wr_take    = access & PWRITE_I & st.pready & addr_ok;
    // only the low byte lane carries data; upper lanes are ignored
    lane0      = PSTRB_I[0];
    wbyte      = PWDATA_I[PORT_W-1:0];
  end

  always_comb
  begin
    next_st = st;

    // one wait state: the first access cycle prepares the answer
    next_st.pready = access & ~st.pready;

    if (access && !st.pready)
    begin
      next_st.pslverr = ~addr_ok;
      next_st.prdata  = RDATA_RST;
      if (addr_ok && !PWRITE_I)
      begin
        if (is_cut_reg)
          next_st.prdata = {30'h0, st.cut_seen};
        else
        begin
          unique case (reg_sel)
            REG_DATA:
              next_st.prdata = {24'h0, readback[slot]};
            REG_DIR, REG_DIR_SET, REG_DIR_CLR:
              next_st.prdata = {24'h0, st.dir[slot]};
          endcase
        end
      end
    end
    else if (!access)
    begin
      next_st.pslverr = 1'b0;
    end

    // software writes
    if (wr_take && lane0 && !is_cut_reg)
    begin
      unique case (reg_sel)
        REG_DATA:
          // latch updates in either direction; pin follows only when output
          next_st.lat[slot] = wbyte;
        REG_DIR:
          next_st.dir[slot] = wbyte;
        REG_DIR_SET:
          // set and clear aliases change single pins without read-modify-write
          next_st.dir[slot] = st.dir[slot] | wbyte;
        REG_DIR_CLR:
          next_st.dir[slot] = st.dir[slot] & ~wbyte;
      endcase
    end

    // cut status is write-one-to-clear
    if (wr_take && lane0 && is_cut_reg)
    begin
      next_st.cut_seen = st.cut_seen & ~PWDATA_I[1:0];
    end

    // cut edges win over a software write in the same cycle
    if (port4_fall)
    begin
      next_st.dir[PORT4_SLOT]      = '0;
      next_st.cut_seen[CUT_BIT_P4] = 1'b1;
    end
    if (port6_fall)
    begin
      next_st.dir[PORT6_SLOT]      = '0;
      next_st.cut_seen[CUT_BIT_P6] = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      st.lat      <= {PORT_NUM{LATCH_RST}};
      st.dir      <= {PORT_NUM{DIR_RST}};
      st.cut_seen <= CUT_RST;
      st.prdata   <= RDATA_RST;
      st.pready   <= 1'b0;
      st.pslverr  <= 1'b0;
    end
    else
      st <= next_st;
  end

  assign PRDATA_O  = st.prdata;
  assign PREADY_O  = st.pready;
  assign PSLVERR_O = st.pslverr & st.pready;

endmodule : gpio_ports
`default_nettype wire

//--- tb/gpio_ports_props.sv
// checker for the gpio port block
// assumes the top ports of gpio_ports
`timescale 1ns/10ps
`default_nettype none
module gpio_ports_props
  import gpio_pkg::*;
(
  input wire logic                            REF_CLK_I,
  input wire logic                            SYS_RST_I,
  input wire logic                            PSEL_I,
  input wire logic                            PENABLE_I,
  input wire logic [ADDR_W-1:0]               PADDR_I,
  input wire logic [31:0]                     PRDATA_O,
  input wire logic                            PREADY_O,
  input wire logic                            PSLVERR_O,
  input wire logic [PORT_NUM-1:0][PORT_W-1:0] PIN_O,
  input wire logic [PORT_NUM-1:0][PORT_W-1:0] PIN_OE_O,
  input wire logic [PORT_NUM-1:0][PORT_W-1:0] PERIPH_OE_I,
  input wire logic [PORT_NUM-1:0][PORT_W-1:0] PERIPH_OUT_I,
  input wire logic                            PORT4_OUTPUT_CUT_N_I,
  input wire logic                            PORT6_OUTPUT_CUT_N_I
);
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  property p_rdy_wait;
    (PSEL_I && !PENABLE_I) ##1 PENABLE_I |=> PREADY_O;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("ready late");
  property p_err_map;
    PREADY_O |-> PSLVERR_O == (PADDR_I[7] || |PADDR_I[1:0] || (&PADDR_I[6:4] && |PADDR_I[3:2]));
  endproperty
  a_err_map: assert property (p_err_map) else $error("bad error flag");
  property p_rd_hi;
    PREADY_O |-> PRDATA_O[31:8] == 24'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("read high bits set");
  property p_per_oe;
    !$past(SYS_RST_I) |-> (PIN_OE_O & $past(PERIPH_OE_I)) == $past(PERIPH_OE_I);
  endproperty
  a_per_oe: assert property (p_per_oe) else $error("peripheral not driving");
  property p_per_out;
    !$past(SYS_RST_I) |-> (PIN_O & $past(PERIPH_OE_I)) == ($past(PERIPH_OUT_I) & $past(PERIPH_OE_I));
  endproperty
  a_per_out: assert property (p_per_out) else $error("peripheral value lost");
  // software quiet assumed: a dir write may legally re-enable pins
  property p_cut4;
    $fell(PORT4_OUTPUT_CUT_N_I) ##1 (!PSEL_I && PERIPH_OE_I[PORT4_SLOT] == 8'h00)[*5]
      |-> PIN_OE_O[PORT4_SLOT] == 8'h00;
  endproperty
  a_cut4: assert property (p_cut4) else $error("port4 still driven");
  property p_cut6;
    $fell(PORT6_OUTPUT_CUT_N_I) ##1 (!PSEL_I && PERIPH_OE_I[PORT6_SLOT] == 8'h00)[*5]
      |-> PIN_OE_O[PORT6_SLOT] == 8'h00;
  endproperty
  a_cut6: assert property (p_cut6) else $error("port6 still driven");
  property p_rst;
    $fell(SYS_RST_I) |-> PIN_OE_O == '0 && !PREADY_O;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule : gpio_ports_props
bind gpio_ports gpio_ports_props chk_u (.REF_CLK_I, .SYS_RST_I, .PSEL_I, .PENABLE_I,
  .PADDR_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .PIN_O, .PIN_OE_O, .PERIPH_OE_I,
  .PERIPH_OUT_I, .PORT4_OUTPUT_CUT_N_I, .PORT6_OUTPUT_CUT_N_I);
`default_nettype wire

//--- tb/gpio_pin_model.sv
// board model of the port pins
// assumes bench board sources override the port
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_model
  import gpio_pkg::*;
(
  input  wire logic                            clk_i,
  input  wire logic [PORT_NUM-1:0][PORT_W-1:0] drv_i,
  input  wire logic [PORT_NUM-1:0][PORT_W-1:0] oe_i,
  input  wire logic [PORT_NUM-1:0][PORT_W-1:0] ext_en_i,
  input  wire logic [PORT_NUM-1:0][PORT_W-1:0] ext_i,
  output logic      [PORT_NUM-1:0][PORT_W-1:0] lvl_o
);
  logic [PORT_NUM-1:0][PORT_W-1:0] last = '0;
  // a strong board source beats the port, like a heavy load
  // an undriven pin wanders so a stale level never passes
  assign lvl_o = (ext_en_i & ext_i) | (~ext_en_i & oe_i & drv_i)
               | (~ext_en_i & ~oe_i & ~last);
  always @(posedge clk_i)
    last <= lvl_o;
endmodule : gpio_pin_model
`default_nettype wire

//--- tb/test_gpio_ports_with_output_cut.sv
// self-checking bench for the gpio ports
// assumes gpio_ports, the pin model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module test_gpio_ports_with_output_cut;
  import gpio_pkg::*;
  typedef logic [PORT_NUM-1:0][PORT_W-1:0] pins_t;
  typedef struct packed {logic rd; logic err; logic [31:0] data;} note_s;
  logic        clk, rst, psel, pen, pwr, c4, c6, pready, pslverr;
  logic [7:0]  paddr, d, m, o;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  pins_t       pin_in, pin_out, pin_oe, poe, pout, ext_en, ext_val;
  note_s       notes[$];
  note_s       n;
  int          fails = 0, n_compared = 0, cyc = 0, sl;
  gpio_ports dut_u (.REF_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .PIN_I(pin_in), .PIN_O(pin_out), .PIN_OE_O(pin_oe),
    .PERIPH_OE_I(poe), .PERIPH_OUT_I(pout), .PORT4_OUTPUT_CUT_N_I(c4), .PORT6_OUTPUT_CUT_N_I(c6));
  gpio_pin_model pins_u (.clk_i(clk), .drv_i(pin_out), .oe_i(pin_oe),
    .ext_en_i(ext_en), .ext_i(ext_val), .lvl_o(pin_in));
  function automatic logic [7:0] ra(input int s, input logic [1:0] r);
    return {1'b0, s[2:0], r, 2'h0};
  endfunction : ra
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic conclude();
    $display("compared %0d wrong %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // x is write data, or the expected byte of a read
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] x, input logic e);
    @(posedge clk);
    notes.push_back({~w, e, 24'h0, x});
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= {24'h0, x};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  always @(posedge clk)
    if (pready === 1'b1)
    begin
      // an answer with no request behind it is a fault of its own
      if (notes.size() == 0)
        check("pending notes", 32'h1, 32'h0);
      else
      begin
        n = notes.pop_front();
        check("slverr", {31'h0, n.err}, {31'h0, pslverr});
        if (n.rd)
          check("rdata", n.data, prdata);
      end
    end
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      conclude();
    end
  end
  initial
  begin
    {rst, psel, pen, pwr, c4, c6, paddr, pwdata, pstrb} = {6'b100011, 40'h0, 4'hf};
    poe     = '0;
    pout    = '0;
    ext_en  = '1;
    ext_val = '0;
    void'($urandom(42268));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int s = 0; s < 7; s++)
      ext_val[s] <= 8'($urandom);
    for (int s = 0; s < 7; s++)
    begin
      apb(0, ra(s, REG_DIR), 8'h00, 0);
      apb(0, ra(s, REG_DATA), ext_val[s], 0);
      check("oe", 32'h0, {24'h0, pin_oe[s]});
    end
    $display("reset test end");
    for (int s = 0; s < 7; s++)
    begin
      d = 8'($urandom);
      m = 8'($urandom);
      o = 8'h1 << $urandom_range(7);
      apb(1, ra(s, REG_DATA), d, 0);
      apb(1, ra(s, REG_DIR), m, 0);
      repeat (2) @(posedge clk);
      check("oe", {24'h0, m}, {24'h0, pin_oe[s]});
      check("drive", {24'h0, d & m}, {24'h0, pin_out[s] & m});
      apb(0, ra(s, REG_DATA), (d & m) | (ext_val[s] & ~m), 0);
      apb(1, ra(s, REG_DIR_SET), o, 0);
      apb(1, ra(s, REG_DIR_CLR), {o[0], o[7:1]}, 0);
      apb(0, ra(s, REG_DIR), (m | o) & ~{o[0], o[7:1]}, 0);
    end
    apb(1, ra(6, REG_DIR), 8'hff, 0);
    pstrb <= 4'h0;
    apb(1, ra(6, REG_DATA), ~d, 0);
    pstrb <= 4'hf;
    apb(0, ra(6, REG_DATA), d, 0);
    apb(1, 8'h74, 8'hff, 1);
    apb(0, 8'h81, 8'h00, 1);
    apb(0, 8'h12, 8'h00, 1);
    $display("port test end");
    for (int k = 0; k < 2; k++)
    begin
      sl = k ? int'(PORT6_SLOT) : int'(PORT4_SLOT);
      apb(1, ra(sl, REG_DIR), 8'hff, 0);
      apb(1, ra(3, REG_DIR), 8'hff, 0);
      if (k)
        c6 <= 1'b0;
      else
        c4 <= 1'b0;
      repeat (6) @(posedge clk);
      check("cut oe", 32'h0, {24'h0, pin_oe[sl]});
      apb(0, ra(sl, REG_DIR), 8'h00, 0);
      apb(0, ra(3, REG_DIR), 8'hff, 0);
      apb(0, CUT_STATUS_ADDR, 8'h1 << k, 0);
      apb(1, CUT_STATUS_ADDR, 8'h03, 0);
      apb(0, CUT_STATUS_ADDR, 8'h00, 0);
      {c4, c6} <= 2'b11;
    end
    $display("cut test end");
    for (int i = 0; i < 2; i++)
    begin
      m = i ? 8'hff : 8'h00;
      o = 8'($urandom);
      d = 8'($urandom);
      apb(1, ra(1, REG_DIR), m, 0);
      poe[1]  <= o;
      pout[1] <= d;
      repeat (3) @(posedge clk);
      check("periph oe", {24'h0, m | o}, {24'h0, pin_oe[1]});
      check("periph out", {24'h0, d & o}, {24'h0, pin_out[1] & o});
    end
    $display("peripheral test end");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(0, ra(1, REG_DIR), 8'h00, 0);
    apb(0, ra(1, REG_DATA), ext_val[1], 0);
    $display("mid reset test end");
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule : test_gpio_ports_with_output_cut
`default_nettype wire
